// file: rtl/ctq_transmit_queue.sv
`timescale 1ns/100ps

// Behaviour
// RULE_01: write completes at once, queue drains later
// RULE_02: write success set when queue fully sent
// RULE_03: accepted write clears write success
// RULE_04: untimed frame follows timed frames without spacing
// RULE_05: timed schedule ignores untimed frames
// RULE_06: full queue rejects write, overflow code
// RULE_07: bus trouble gives warning code, write succeeds
// RULE_08: bus errors retried until frame acknowledged
// RULE_09: host retries overflow once after waiting
// RULE_10: queue length zero overwrites pending frame
// RULE_11: type code selects data, remote, LIN; LIN codes are refused here with PSLVERR
// RULE_12: identifier standard, extended when bit set
// RULE_13: data frame sends count bytes, max eight
// RULE_14: remote frame carries count, no data
// RULE_15: write success asserted from reset
// RULE_16: parameter depth, first-in first-out order
module ctq_transmit_queue
  import ctq_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int TICK  = TICK_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output ctq_frame_t       TX_FRAME,
  output logic             TX_VALID,
  input  wire logic        TX_DONE,
  input  wire logic        TX_ERROR,
  input  wire logic        TX_BUS_FAULT,
  output logic             IRQ
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = PW + 1;
  localparam int TW = (TICK > 1) ? $clog2(TICK) : 1;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [11:0] a);
    return a == OFS_STATUS || a == OFS_IRQ_STAT || a == OFS_IRQ_MASK ||
           a == OFS_DESC_TYPE || a == OFS_DESC_IDENT || a == OFS_DESC_COUNT ||
           a == OFS_DATA_LO || a == OFS_DATA_HI || a == OFS_DESC_DELTA ||
           a == OFS_COMMIT || a == OFS_RESULT || a == OFS_QUEUE_LEN;
  endfunction

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // ****************************************************************
  // apb access
  // ****************************************************************
  logic        wr;
  logic        rd;
  logic [31:0] d_type;
  logic [31:0] d_ident;
  logic [31:0] d_count;
  logic [31:0] d_lo;
  logic [31:0] d_hi;
  logic [31:0] d_delta;
  logic [CW-1:0] queue_len;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  logic [31:0] result;

  assign wr     = PSEL && PENABLE && PWRITE;
  assign rd     = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1; // RULE_01

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      d_type  <= TYPE_DATA;
      d_ident <= '0;
      d_count <= '0;
      d_lo    <= '0;
      d_hi    <= '0;
      d_delta <= '0;
    end else if (wr) begin
      case (PADDR)
        OFS_DESC_TYPE:  d_type  <= strobe(d_type, PWDATA, PSTRB);
        OFS_DESC_IDENT: d_ident <= strobe(d_ident, PWDATA, PSTRB);
        OFS_DESC_COUNT: d_count <= strobe(d_count, PWDATA, PSTRB);
        OFS_DATA_LO:    d_lo    <= strobe(d_lo, PWDATA, PSTRB);
        OFS_DATA_HI:    d_hi    <= strobe(d_hi, PWDATA, PSTRB);
        OFS_DESC_DELTA: d_delta <= strobe(d_delta, PWDATA, PSTRB);
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      queue_len <= CW'(DEPTH);
      irq_mask  <= IRQ_MASK_RST;
    end else if (wr) begin
      if (PADDR == OFS_QUEUE_LEN) begin
        queue_len <= (PWDATA > 32'(DEPTH)) ? CW'(DEPTH) : PWDATA[CW-1:0];
      end
      if (PADDR == OFS_IRQ_MASK) begin
        irq_mask <= PWDATA[IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // descriptor build
  // ****************************************************************
  logic       type_ok;
  logic       is_remote;
  logic [3:0] len;
  logic [63:0] raw_data;
  ctq_entry_t new_entry;

  assign is_remote = (d_type == TYPE_REMOTE); // RULE_11
  // lin types are refused with PSLVERR and never enter this queue
  assign type_ok   = (d_type == TYPE_DATA) || is_remote; // RULE_11
  assign len       = (d_count > MAX_BYTES) ? MAX_BYTES[3:0] : d_count[3:0]; // RULE_13
  assign raw_data  = {d_hi, d_lo};

  always_comb begin
    new_entry                = '0;
    new_entry.frame.remote   = is_remote;
    new_entry.frame.extended = d_ident[EXT_SEL_BIT]; // RULE_12
    new_entry.frame.ident    = d_ident[EXT_SEL_BIT] ? d_ident[28:0] :
                               {18'h0_0000, d_ident[10:0]}; // RULE_12
    new_entry.frame.dlc      = len; // RULE_14
    for (int i = 0; i < 8; i++) begin
      if (!is_remote && 4'(i) < len) begin
        new_entry.frame.data[i*8 +: 8] = raw_data[i*8 +: 8]; // RULE_13 RULE_14
      end
    end
    new_entry.delta = d_delta[TIME_W-1:0];
  end

  // ****************************************************************
  // queue storage
  // ****************************************************************
  ctq_entry_t    mem [DEPTH];
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic [CW-1:0] count;
  logic          full;
  logic          commit_hit;
  logic          commit_ok;
  logic          overwrite;
  logic          launch;
  logic          timed_in;

  assign commit_hit = wr && (PADDR == OFS_COMMIT);
  assign timed_in   = PWDATA[COMMIT_TIMED_BIT];
  assign full       = (queue_len != '0) && (count >= queue_len); // RULE_06
  assign commit_ok  = commit_hit && type_ok && !full;
  // the slot being launched this cycle is gone, so a fresh push goes normally
  assign overwrite  = commit_ok && (queue_len == '0) && (count != '0) && !launch; // RULE_10

  always_ff @(posedge CLK_SYS) begin
    if (commit_ok) begin
      mem[overwrite ? rd_ptr : wr_ptr]       <= new_entry; // RULE_10 RULE_16
      mem[overwrite ? rd_ptr : wr_ptr].timed <= timed_in; // RULE_04
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (commit_ok && !overwrite) begin
        wr_ptr <= bump(wr_ptr); // RULE_16
      end
      if (launch) begin
        rd_ptr <= bump(rd_ptr); // RULE_16
      end
      count <= CW'(count + CW'(commit_ok && !overwrite) - CW'(launch));
    end
  end

  // ****************************************************************
  // time base and schedule
  // ****************************************************************
  logic [TW-1:0]     presc;
  logic [TIME_W-1:0] now;
  logic [TIME_W-1:0] sched_base;
  logic              sched_valid;
  logic              due;
  ctq_entry_t        head;

  assign head = mem[rd_ptr];
  assign due  = !sched_valid || (TIME_W'(now - sched_base) >= head.delta); // RULE_05

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      presc <= '0;
      now   <= '0;
    end else if (presc == TW'(TICK - 1)) begin
      presc <= '0;
      now   <= TIME_W'(now + 1'b1);
    end else begin
      presc <= TW'(presc + 1'b1);
    end
  end

  // the base advances by the programmed delta, so late starts do not drift the schedule
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sched_base  <= '0;
      sched_valid <= 1'b0;
    end else if (launch && head.timed) begin
      sched_base  <= sched_valid ? TIME_W'(sched_base + head.delta) : now; // RULE_05
      sched_valid <= 1'b1;
    end
  end

  // ****************************************************************
  // transmit control
  // ****************************************************************
  ctq_state_t state;
  logic       all_sent;
  logic       write_success;
  logic [7:0] retries;
  logic       fault_q;

  assign launch   = (state == CTQ_IDLE) && (count != '0) && (!head.timed || due); // RULE_04
  assign all_sent = (state == CTQ_BUSY) && TX_DONE && (count == '0) && !commit_ok;
  assign TX_VALID = (state == CTQ_BUSY);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state    <= CTQ_IDLE;
      TX_FRAME <= '0;
    end else begin
      case (state)
        CTQ_IDLE: begin
          if (launch) begin
            TX_FRAME <= head.frame;
            state    <= CTQ_BUSY;
          end
        end
        CTQ_BUSY: begin
          // on an error the controller resends the same frame; only an ack ends it
          if (TX_DONE) begin
            state <= CTQ_IDLE; // RULE_08
          end
        end
        default: state <= CTQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      retries <= '0;
      fault_q <= 1'b0;
    end else begin
      fault_q <= TX_BUS_FAULT;
      if (TX_DONE) begin
        retries <= '0;
      end else if (TX_ERROR && retries != 8'hFF) begin
        retries <= 8'(retries + 1'b1); // RULE_08
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      write_success <= WRITE_SUCCESS_RST; // RULE_15
    end else if (commit_ok) begin
      write_success <= 1'b0; // RULE_03
    end else if (all_sent) begin
      write_success <= 1'b1; // RULE_02
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      result <= RESULT_RST;
    end else if (commit_hit && type_ok) begin
      if (full) begin
        result <= CODE_QUEUE_OVERFLOW; // RULE_06
      end else if (TX_BUS_FAULT || retries != '0) begin
        result <= CODE_COMM_WARNING; // RULE_07
      end else begin
        result <= CODE_OK;
      end
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_SENT]      = (state == CTQ_BUSY) && TX_DONE;
    irq_set[IRQ_OVERFLOW]  = commit_hit && type_ok && full; // RULE_06
    irq_set[IRQ_COMM_WARN] = TX_ERROR || (TX_BUS_FAULT && !fault_q); // RULE_07
    irq_set[IRQ_ALL_SENT]  = all_sent;
  end

  assign irq_clr = (wr && PADDR == OFS_IRQ_STAT) ? PWDATA[IRQ_W-1:0] : '0;

  // set wins over a same-cycle clear
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ****************************************************************
  // read path and error answer
  // ****************************************************************
  logic [31:0] status;

  always_comb begin
    status                              = '0;
    status[ST_WRITE_SUCCESS]            = write_success;
    status[ST_BUSY]                     = (state == CTQ_BUSY);
    status[ST_FULL]                     = full;
    status[ST_BUS_FAULT]                = TX_BUS_FAULT;
    status[ST_COUNT_LSB +: 8]           = 8'(count);
    status[ST_RETRY_LSB +: 8]           = retries;
  end

  always_comb begin
    PRDATA = '0;
    if (rd) begin
      case (PADDR)
        OFS_STATUS:     PRDATA = status;
        OFS_IRQ_STAT:   PRDATA = 32'(irq_stat);
        OFS_IRQ_MASK:   PRDATA = 32'(irq_mask);
        OFS_DESC_TYPE:  PRDATA = d_type;
        OFS_DESC_IDENT: PRDATA = d_ident;
        OFS_DESC_COUNT: PRDATA = d_count;
        OFS_DATA_LO:    PRDATA = d_lo;
        OFS_DATA_HI:    PRDATA = d_hi;
        OFS_DESC_DELTA: PRDATA = d_delta;
        OFS_RESULT:     PRDATA = result;
        OFS_QUEUE_LEN:  PRDATA = 32'(queue_len);
        default:        PRDATA = '0;
      endcase
    end
  end

  // unmapped address, rejected commit or unsupported frame type
  assign PSLVERR = PSEL && PENABLE &&
                   (!known(PADDR) || (commit_hit && (full || !type_ok))); // RULE_06

endmodule

// file: inc/ctq_pkg.sv
package ctq_pkg;

  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIME_W        = 16;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT   = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h00C;
  localparam logic [11:0] OFS_DESC_TYPE  = 12'h010;
  localparam logic [11:0] OFS_DESC_IDENT = 12'h014;
  localparam logic [11:0] OFS_DESC_COUNT = 12'h018;
  localparam logic [11:0] OFS_DATA_LO    = 12'h01C;
  localparam logic [11:0] OFS_DATA_HI    = 12'h020;
  localparam logic [11:0] OFS_DESC_DELTA = 12'h024;
  localparam logic [11:0] OFS_COMMIT     = 12'h028;
  localparam logic [11:0] OFS_RESULT     = 12'h02C;
  localparam logic [11:0] OFS_QUEUE_LEN  = 12'h030;

  // ****************************************************************
  // result codes and descriptor encodings
  // ****************************************************************
  localparam logic [31:0] CODE_OK            = 32'h0000_0000;
  localparam logic [31:0] CODE_QUEUE_OVERFLOW = 32'hBFF6_2008;
  localparam logic [31:0] CODE_COMM_WARNING  = 32'h3FF6_200B;
  localparam logic [31:0] TYPE_DATA          = 32'h0000_0000;
  localparam logic [31:0] TYPE_REMOTE        = 32'h0000_0001;
  localparam logic [31:0] TYPE_LIN_FIRST     = 32'h0000_0010;
  localparam int          EXT_SEL_BIT        = 29;
  localparam logic [31:0] MAX_BYTES          = 32'h0000_0008;
  localparam int          COMMIT_TIMED_BIT   = 0;

  // ****************************************************************
  // status and interrupt fields
  // ****************************************************************
  localparam int ST_WRITE_SUCCESS = 0;
  localparam int ST_BUSY          = 1;
  localparam int ST_FULL          = 2;
  localparam int ST_BUS_FAULT     = 3;
  localparam int ST_COUNT_LSB     = 8;
  localparam int ST_RETRY_LSB     = 16;
  localparam int IRQ_SENT         = 0;
  localparam int IRQ_OVERFLOW     = 1;
  localparam int IRQ_COMM_WARN    = 2;
  localparam int IRQ_ALL_SENT     = 3;
  localparam int IRQ_W            = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic              WRITE_SUCCESS_RST = 1'b1;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST      = 4'h0;
  localparam logic [31:0]       RESULT_RST        = 32'h0000_0000;

  typedef struct packed {
    logic        remote;
    logic        extended;
    logic [28:0] ident;
    logic [3:0]  dlc;
    logic [63:0] data;
  } ctq_frame_t;

  typedef struct packed {
    ctq_frame_t        frame;
    logic              timed;
    logic [TIME_W-1:0] delta;
  } ctq_entry_t;

  typedef enum logic {CTQ_IDLE, CTQ_BUSY} ctq_state_t;

endpackage

// file: bench/ctq_tq_monitor.sv
`timescale 1ns/100ps
module ctq_tq_monitor
  import ctq_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int TICK  = 100
) (
  input logic        CLK_SYS,
  input logic        RST_N,
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [3:0]  PSTRB,
  input logic [31:0] PRDATA,
  input logic        PREADY,
  input logic        PSLVERR,
  input ctq_frame_t  TX_FRAME,
  input logic        TX_VALID,
  input logic        TX_DONE,
  input logic        TX_ERROR,
  input logic        TX_BUS_FAULT,
  input logic        IRQ
);
  // ****************************************************************
  // bus and transmit link checks
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence access_s; PSEL && PENABLE; endsequence
  sequence offer_s; TX_VALID && !TX_DONE; endsequence
  sequence sent_s; TX_VALID && TX_DONE; endsequence
  host_nowait_a: assert property (access_s |-> PREADY)
    else $error("access not answered at once");
  frame_hold_a: assert property (offer_s |=> TX_VALID && $stable(TX_FRAME))
    else $error("offered frame changed or dropped");
  retry_keep_a: assert property (offer_s ##0 TX_ERROR |=> TX_VALID)
    else $error("bus error dropped the frame");
  sent_drop_a: assert property (sent_s |=> !TX_VALID)
    else $error("frame still offered after done");
  remote_nodata_a: assert property (TX_VALID && TX_FRAME.remote |-> TX_FRAME.data == 64'h0)
    else $error("remote frame carries data");
  count_max_a: assert property (TX_VALID |-> TX_FRAME.dlc <= 4'h8)
    else $error("length code above eight");
  std_ident_a: assert property (TX_VALID && !TX_FRAME.extended
      |-> TX_FRAME.ident[28:11] == 18'h0)
    else $error("standard identifier wider than 11 bits");
  data_pad_a: assert property (TX_VALID && !TX_FRAME.remote
      |-> (TX_FRAME.data >> {TX_FRAME.dlc, 3'b000}) == 64'h0)
    else $error("bytes beyond the count not zero");
endmodule

bind ctq_transmit_queue ctq_tq_monitor #(.DEPTH(DEPTH), .TICK(TICK)) mon (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TX_FRAME(TX_FRAME), .TX_VALID(TX_VALID), .TX_DONE(TX_DONE),
  .TX_ERROR(TX_ERROR), .TX_BUS_FAULT(TX_BUS_FAULT), .IRQ(IRQ));

// file: bench/ctq_can_ctrl_model.sv
`timescale 1ns/100ps
module ctq_can_ctrl_model
  import ctq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tx_valid,
  input  ctq_frame_t      tx_frame,
  input  wire logic [7:0] ack_wait,
  input  wire logic [7:0] err_count,
  input  wire logic       fault,
  output logic            tx_done,
  output logic            tx_error,
  output logic            tx_bus_fault
);
  // ****************************************************************
  // controller: retries, then acknowledge after ack_wait cycles
  // ****************************************************************
  ctq_frame_t sent_q[$];
  int         stamp_q[$];
  int         cyc = 0;
  logic [7:0] cnt = 8'h00;
  // pulses are driven only here; they settle low at the first edge, inside reset
  // fault level is held by the bench, as a dead bus would hold it
  assign tx_bus_fault = fault;
  always @(posedge clk) begin
    tx_done  <= 1'b0;
    tx_error <= 1'b0;
    cyc      <= cyc + 1;
    if (!rst_n) begin
      cnt <= 8'h00;
    end else if (tx_valid && !tx_done) begin
      cnt <= cnt + 8'h01;
      // error pulses first; ack_wait must not be below err_count
      if (cnt < err_count) begin
        tx_error <= 1'b1;
      end else if (cnt >= ack_wait) begin
        tx_done <= 1'b1;
        cnt     <= 8'h00;
        sent_q.push_back(tx_frame);
        stamp_q.push_back(cyc);
      end
    end
  end
endmodule

// file: bench/test_can_transmit_queue.sv
`timescale 1ns/100ps
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", w, e, g); end end
module test_can_transmit_queue
  import ctq_pkg::*;
;
  localparam int TK = 2;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rdata, ty, id, cnt;
  logic        pready, pslverr, rerr, tx_valid, tx_done, tx_error, tx_fault, irq;
  logic        fault     = 1'b0;
  logic [7:0]  ack_wait  = 8'h04;
  logic [7:0]  err_count = 8'h00;
  ctq_frame_t  tx_frame;
  int          failures = 0, n_compared = 0, n0, k, d;

  always #5 clk_sys = ~clk_sys;

  ctq_transmit_queue #(.DEPTH(4), .TICK(TK)) dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TX_FRAME(tx_frame), .TX_VALID(tx_valid), .TX_DONE(tx_done),
    .TX_ERROR(tx_error), .TX_BUS_FAULT(tx_fault), .IRQ(irq));
  ctq_can_ctrl_model ctl (
    .clk(clk_sys), .rst_n(rst_n), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .ack_wait(ack_wait), .err_count(err_count), .fault(fault), .tx_done(tx_done),
    .tx_error(tx_error), .tx_bus_fault(tx_fault));

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [31:0] t, i, c, dl, input logic tm);
    apb(1, OFS_DESC_TYPE, t);
    apb(1, OFS_DESC_IDENT, i);
    apb(1, OFS_DESC_COUNT, c);
    apb(1, OFS_DATA_LO, 32'h4433_2211);
    apb(1, OFS_DATA_HI, 32'h8877_6655);
    apb(1, OFS_DESC_DELTA, dl);
    apb(1, OFS_COMMIT, {31'h0, tm});
  endtask
  task automatic drain;
    for (int i = 0; i < 1000; i++) begin
      apb(0, OFS_STATUS, 32'h0);
      if (rdata[ST_WRITE_SUCCESS] === 1'b1) break;
    end
  endtask
  function automatic ctq_frame_t expf(input logic [31:0] t, i, c);
    ctq_frame_t f;
    logic [3:0] n;
    n = (c > 32'h0000_0008) ? 4'h8 : c[3:0];
    f.remote   = t[0];
    f.extended = i[29];
    f.ident    = i[29] ? i[28:0] : {18'h0, i[10:0]};
    f.dlc      = n;
    f.data     = t[0] ? 64'h0 : 64'h8877_6655_4433_2211 & ~({64{1'b1}} << {n, 3'b000});
    return f;
  endfunction
  task automatic print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(0, OFS_STATUS, 32'h0);
    `CHK("ws reset", 1'b1, rdata[ST_WRITE_SUCCESS])
    apb(0, OFS_RESULT, 32'h0);
    `CHK("result reset", RESULT_RST, rdata)
    apb(0, 12'h000, 32'h0);
    `CHK("unmapped", 1'b1, rerr)
    $display("done reset");
    for (k = 0; k < 11; k++) begin
      id  = k[0] ? 32'h2ABC_DE12 : 32'h0000_0F5A;
      ty  = (k == 10) ? TYPE_REMOTE : TYPE_DATA;
      cnt = (k == 10) ? 32'h0000_0005 : k;
      send(ty, id, cnt, 32'h0, 1'b0);
      `CHK("commit", 1'b0, rerr)
      apb(0, OFS_STATUS, 32'h0);
      `CHK("ws cleared", 1'b0, rdata[ST_WRITE_SUCCESS])
      drain();
      `CHK("ws set", 1'b1, rdata[ST_WRITE_SUCCESS])
      `CHK("frame", expf(ty, id, cnt), ctl.sent_q[k])
    end
    send(TYPE_LIN_FIRST, 32'h1, 32'h1, 32'h0, 1'b0);
    `CHK("lin refused", 1'b1, rerr)
    apb(1, OFS_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irq)
    apb(1, OFS_IRQ_MASK, 32'h0000_0008);
    @(posedge clk_sys);
    `CHK("irq all sent", 1'b1, irq)
    apb(1, OFS_IRQ_STAT, 32'h0000_000F);
    @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    $display("done formats");
    ack_wait <= 8'hC8;
    apb(1, OFS_QUEUE_LEN, 32'h0000_0002);
    n0 = ctl.sent_q.size();
    for (k = 0; k < 4; k++) begin
      send(TYPE_DATA, 32'h100 + k, 32'h1, 32'h0, 1'b0);
      `CHK("full refuse", k == 3, rerr)
    end
    apb(0, OFS_RESULT, 32'h0);
    `CHK("overflow code", CODE_QUEUE_OVERFLOW, rdata)
    drain();
    send(TYPE_DATA, 32'h103, 32'h1, 32'h0, 1'b0);
    `CHK("retry", 1'b0, rerr)
    drain();
    for (k = 0; k < 4; k++)
      `CHK("fifo", 29'h100 + k, ctl.sent_q[n0 + k].ident)
    $display("done overflow");
    ack_wait  <= 8'h04;
    fault     <= 1'b1;
    err_count <= 8'h03;
    send(TYPE_DATA, 32'h123, 32'h0, 32'h0, 1'b0);
    `CHK("warn no fail", 1'b0, rerr)
    apb(0, OFS_RESULT, 32'h0);
    `CHK("warn code", CODE_COMM_WARNING, rdata)
    drain();
    `CHK("retried frame", 29'h123, ctl.sent_q[n0 + 4].ident)
    fault     <= 1'b0;
    err_count <= 8'h00;
    $display("done warning");
    ack_wait <= 8'hC8;
    apb(1, OFS_QUEUE_LEN, 32'h0);
    for (k = 0; k < 3; k++)
      send(TYPE_DATA, 32'h201 + k, 32'h0, 32'h0, 1'b0);
    drain();
    `CHK("overwrite n", n0 + 7, ctl.sent_q.size())
    `CHK("overwrite", 29'h203, ctl.sent_q[n0 + 6].ident)
    $display("done overwrite");
    ack_wait <= 8'h04;
    apb(1, OFS_QUEUE_LEN, 32'h0000_0004);
    n0 = ctl.sent_q.size();
    send(TYPE_DATA, 32'h301, 32'h0, 32'h0, 1'b1);
    send(TYPE_DATA, 32'h302, 32'h0, 32'h28, 1'b1);
    send(TYPE_DATA, 32'h303, 32'h0, 32'h0, 1'b0);
    send(TYPE_DATA, 32'h304, 32'h0, 32'h28, 1'b1);
    drain();
    d = ctl.stamp_q[n0 + 2] - ctl.stamp_q[n0 + 1];
    `CHK("untimed gap", 1'b1, d <= 10)
    d = ctl.stamp_q[n0 + 3] - ctl.stamp_q[n0 + 1];
    `CHK("timed gap", 1'b1, d >= 40 * TK - 2 && d <= 40 * TK + 2)
    $display("done timing");
    print_verdict();
  end
endmodule
